// ---- rtl/conv_backend.v ----
/*
 digital back end of a paired converter: result storage, monitor, flags, dma request,
 master/slave start sequencing. assumes APB master with word accesses, converter results
 arriving as one-cycle strobes, and a one-cycle converter_clock enable pulse.
*/
// Overview of operation
// - ordinary end writes the single ordinary result register
// - preempted end writes result register of its sequence position
// - 12-bit result right or left aligned in 16 bits by alignment bit
// - preempted result minus offset of its sequence position, sign extended above
// - ordinary readable by cpu or dma, preempted only by cpu
// - dma request on every ordinary result update while enabled
// - slave ordinary results land in master register, master dma
// - monitored result above high or below low sets out-of-range flag
// - single-channel bit limits monitoring to the selected channel
// - monitor compares raw 12-bit result, no offset or alignment
// - five flags; pend, cend, range raise interrupt when enabled
// - first two converters share an interrupt line, third separate
// - regular simultaneous: master regular trigger starts both
// - preempted simultaneous: master preempted trigger starts both
// - combined: each trigger starts its group on both
// - alternate: successive preempted triggers go master then slave
// - regular plus alternate: preempt halts regular, ignore until resume
// - fast switch: slave now, then alternate every 7 converter clocks
// - slow switch: alternate starts every 14 converter clocks
// - combined switch: preempt interrupts, resume with second converter
// - 4-bit pairing mode field, codes above 1001 not allowed
// - flags cleared by writing zero; cend also by ordinary read
`include "conv_backend_defs.vh"
module conv_backend #(
   parameter RES_W = 12
) (
   input wire ref_clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire converter_clock,
   input wire ord_trigger,
   input wire pre_trigger,
   input wire ord_done,
   input wire ord_from_slave,
   input wire [RES_W-1:0] ord_value,
   input wire [4:0] ord_channel,
   input wire pre_done,
   input wire [1:0] pre_position,
   input wire [RES_W-1:0] pre_value,
   input wire [4:0] pre_channel,
   input wire pre_group_end,
   output reg master_ord_start,
   output reg slave_ord_start,
   output reg master_pre_start,
   output reg slave_pre_start,
   output reg ord_halt,
   output reg dma_request,
   input wire dma_ack,
   output wire irq_shared
);
   // ==========================================================
   // registers
   reg [4:0] status_flags;
   reg [31:0] control_one;
   reg [31:0] control_two;
   reg [31:0] sample_time_one;
   reg [31:0] sample_time_two;
   reg [RES_W-1:0] preempt_offset_value [0:3];
   reg [RES_W-1:0] monitor_high_bound;
   reg [RES_W-1:0] monitor_low_bound;
   reg [31:0] ordinary_sequence_one;
   reg [31:0] ordinary_sequence_two;
   reg [31:0] ordinary_sequence_three;
   reg [31:0] preempt_sequence;
   reg [15:0] preempt_result_n [0:3];
   reg [31:0] ordinary_result;
   reg [2:0] irq_enable;
   reg [31:0] read_data;
   reg alt_turn;
   reg pre_busy;
   reg sw_active;
   reg sw_turn;
   reg [4:0] sw_count;
   integer i;
   integer j;
   wire [3:0] pairing_mode_select = control_one[`C1_MODE_HI:`C1_MODE_LO];
   wire result_alignment_select = control_two[`C2_ALIGN];
   wire ordinary_dma_enable = control_two[`C2_DMA];
   wire ordinary_monitor_enable = control_one[`C1_OMON];
   wire preempt_monitor_enable = control_one[`C1_PMON];
   wire monitor_single_channel_enable = control_one[`C1_SINGLE];
   wire [4:0] monitor_channel_select = control_one[`C1_CHSEL_HI:`C1_CHSEL_LO];
   // ==========================================================
   // helpers
   // alignment of a 16-bit signed or plain value
   function [15:0] align_value;
      input [15:0] v;
      input left;
      begin
         if (left)
            align_value = {v[11:0], 4'h0};
         else
            align_value = v;
      end
   endfunction
   // window check on the raw value
   function out_of_window;
      input [RES_W-1:0] v;
      input [4:0] ch;
      input en;
      begin
         out_of_window = en && (!monitor_single_channel_enable || ch == monitor_channel_select)
            && (v > monitor_high_bound || v < monitor_low_bound);
      end
   endfunction
   // ==========================================================
   // apb access decode, zero wait states, word accesses only
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFF_IRQ_EN);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = read_data;
   wire ord_read = rd && paddr == `OFF_ORES;
   // ==========================================================
   // result path
   wire [RES_W:0] pre_diff = {1'b0, pre_value} - {1'b0, preempt_offset_value[pre_position]};
   wire [15:0] pre_signed = {{(16-RES_W){pre_diff[RES_W]}}, pre_diff[RES_W-1:0]};
   wire [15:0] pre_aligned = align_value(pre_signed, result_alignment_select);
   wire [15:0] ord_aligned = align_value({4'h0, ord_value}, result_alignment_select);
   wire range_hit = (ord_done && out_of_window(ord_value, ord_channel, ordinary_monitor_enable))
      || (pre_done && out_of_window(pre_value, pre_channel, preempt_monitor_enable));
   // result registers, each held until its group converts again
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ordinary_result <= `RST_ZERO;
         for (i = 0; i < 4; i = i + 1)
            preempt_result_n[i] <= 16'h0000;
      end
      else
      begin
         if (ord_done)
            ordinary_result <= {16'h0000, ord_aligned};
         if (pre_done)
            preempt_result_n[pre_position] <= pre_aligned;
      end
   end
   // dma request held until acknowledged, only the ordinary result drives it
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         dma_request <= 1'b0;
      else if (ord_done && ordinary_dma_enable)
         dma_request <= 1'b1;
      else if (dma_ack)
         dma_request <= 1'b0;
   end
   // ==========================================================
   // status flags: hardware set wins over software clear
   wire any_start_ord = master_ord_start || slave_ord_start;
   wire any_start_pre = master_pre_start || slave_pre_start;
   reg [4:0] set_bits;
   reg [4:0] next_flags;
   always @*
   begin
      set_bits = 5'h00;
      set_bits[`ST_RANGE] = range_hit;
      set_bits[`ST_CEND] = ord_done || pre_group_end;
      set_bits[`ST_PEND] = pre_group_end;
      set_bits[`ST_PSTART] = any_start_pre;
      set_bits[`ST_OSTART] = any_start_ord;
      next_flags = status_flags;
      if (wr && paddr == `OFF_STATUS)
         next_flags = status_flags & pwdata[4:0];
      if (ord_read)
         next_flags[`ST_CEND] = 1'b0;
      next_flags = next_flags | set_bits;
   end
   // ==========================================================
   // register writes
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status_flags <= 5'h00;
         control_one <= `RST_ZERO;
         control_two <= `RST_ZERO;
         sample_time_one <= `RST_ZERO;
         sample_time_two <= `RST_ZERO;
         for (j = 0; j < 4; j = j + 1)
            preempt_offset_value[j] <= 12'h000;
         monitor_high_bound <= `RST_HIGH;
         monitor_low_bound <= 12'h000;
         ordinary_sequence_one <= `RST_ZERO;
         ordinary_sequence_two <= `RST_ZERO;
         ordinary_sequence_three <= `RST_ZERO;
         preempt_sequence <= `RST_ZERO;
         irq_enable <= 3'h0;
      end
      else
      begin
         status_flags <= next_flags;
         if (wr)
         begin
            case (paddr)
               `OFF_CTRL_ONE:
               begin
                  control_one <= pwdata;
                  if (pwdata[`C1_MODE_HI:`C1_MODE_LO] > `MODE_ALT)
                     control_one[`C1_MODE_HI:`C1_MODE_LO] <= `MODE_INDEP;
               end
               `OFF_CTRL_TWO: control_two <= pwdata;
               `OFF_SPT_ONE: sample_time_one <= pwdata;
               `OFF_SPT_TWO: sample_time_two <= pwdata;
               `OFF_POFS_ONE: preempt_offset_value[0] <= pwdata[RES_W-1:0];
               `OFF_POFS_TWO: preempt_offset_value[1] <= pwdata[RES_W-1:0];
               `OFF_POFS_THREE: preempt_offset_value[2] <= pwdata[RES_W-1:0];
               `OFF_POFS_FOUR: preempt_offset_value[3] <= pwdata[RES_W-1:0];
               `OFF_HIGH: monitor_high_bound <= pwdata[RES_W-1:0];
               `OFF_LOW: monitor_low_bound <= pwdata[RES_W-1:0];
               `OFF_OSQ_ONE: ordinary_sequence_one <= pwdata;
               `OFF_OSQ_TWO: ordinary_sequence_two <= pwdata;
               `OFF_OSQ_THREE: ordinary_sequence_three <= pwdata;
               `OFF_PSQ: preempt_sequence <= pwdata;
               `OFF_IRQ_EN: irq_enable <= pwdata[2:0];
               default: ;
            endcase
         end
      end
   end
   // ==========================================================
   // read mux, registered on the setup cycle
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         read_data <= `RST_ZERO;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            `OFF_STATUS: read_data <= {27'h0000000, status_flags};
            `OFF_CTRL_ONE: read_data <= control_one;
            `OFF_CTRL_TWO: read_data <= control_two;
            `OFF_SPT_ONE: read_data <= sample_time_one;
            `OFF_SPT_TWO: read_data <= sample_time_two;
            `OFF_POFS_ONE: read_data <= {20'h00000, preempt_offset_value[0]};
            `OFF_POFS_TWO: read_data <= {20'h00000, preempt_offset_value[1]};
            `OFF_POFS_THREE: read_data <= {20'h00000, preempt_offset_value[2]};
            `OFF_POFS_FOUR: read_data <= {20'h00000, preempt_offset_value[3]};
            `OFF_HIGH: read_data <= {20'h00000, monitor_high_bound};
            `OFF_LOW: read_data <= {20'h00000, monitor_low_bound};
            `OFF_OSQ_ONE: read_data <= ordinary_sequence_one;
            `OFF_OSQ_TWO: read_data <= ordinary_sequence_two;
            `OFF_OSQ_THREE: read_data <= ordinary_sequence_three;
            `OFF_PSQ: read_data <= preempt_sequence;
            `OFF_PRES_ONE, `OFF_PRES_TWO, `OFF_PRES_THREE, `OFF_PRES_FOUR:
               read_data <= {16'h0000, preempt_result_n[paddr[3:2] + 2'h1]};
            `OFF_ORES: read_data <= ordinary_result;
            `OFF_IRQ_EN: read_data <= {29'h00000000, irq_enable};
            default: read_data <= `RST_ZERO;
         endcase
      end
   end
   // interrupt: first two converters combine their requests outside onto this line
   assign irq_shared = (status_flags[`ST_PEND] && irq_enable[`IE_PEND])
      || (status_flags[`ST_CEND] && irq_enable[`IE_CEND])
      || (status_flags[`ST_RANGE] && irq_enable[`IE_RANGE]);
   // ==========================================================
   // pairing sequencer
   wire [3:0] m = pairing_mode_select;
   wire reg_sim = (m == `MODE_REG_PRE_SIM) || (m == `MODE_REG_ALT) || (m == `MODE_REG_SIM);
   wire pre_sim = (m == `MODE_REG_PRE_SIM) || (m == `MODE_PRE_SIM)
      || (m == `MODE_PSIM_FAST) || (m == `MODE_PSIM_SLOW);
   wire pre_alt = (m == `MODE_REG_ALT) || (m == `MODE_ALT);
   wire sw_fast = (m == `MODE_FAST) || (m == `MODE_PSIM_FAST);
   wire sw_mode = sw_fast || (m == `MODE_SLOW) || (m == `MODE_PSIM_SLOW);
   wire [4:0] gap = sw_fast ? `FAST_GAP : `SLOW_GAP;
   // in pure switch modes a preempted trigger is not expected and is dropped
   wire pre_ok = pre_trigger && !(m == `MODE_FAST || m == `MODE_SLOW)
      && !(m == `MODE_REG_ALT && pre_busy);
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         master_ord_start <= 1'b0;
         slave_ord_start <= 1'b0;
         master_pre_start <= 1'b0;
         slave_pre_start <= 1'b0;
         ord_halt <= 1'b0;
         alt_turn <= 1'b0;
         pre_busy <= 1'b0;
         sw_active <= 1'b0;
         sw_turn <= 1'b0;
         sw_count <= 5'h00;
      end
      else
      begin
         master_ord_start <= 1'b0;
         slave_ord_start <= 1'b0;
         master_pre_start <= 1'b0;
         slave_pre_start <= 1'b0;
         if (pre_group_end && pre_busy)
         begin
            pre_busy <= 1'b0;
            ord_halt <= 1'b0;
            if (sw_mode && sw_active)
            begin
               sw_turn <= 1'b0;
               sw_count <= 5'h00;
            end
         end
         if (pre_ok)
         begin
            if (pre_alt)
            begin
               master_pre_start <= !alt_turn;
               slave_pre_start <= alt_turn;
               alt_turn <= !alt_turn;
               if (m == `MODE_REG_ALT)
               begin
                  pre_busy <= 1'b1;
                  ord_halt <= 1'b1;
               end
            end
            else if (pre_sim)
            begin
               master_pre_start <= 1'b1;
               slave_pre_start <= 1'b1;
               pre_busy <= 1'b1;
               ord_halt <= sw_mode;
            end
            else
               master_pre_start <= 1'b1;
         end
         else if (ord_trigger && !pre_busy)
         begin
            if (reg_sim)
            begin
               master_ord_start <= 1'b1;
               slave_ord_start <= 1'b1;
            end
            else if (sw_mode)
            begin
               sw_active <= 1'b1;
               sw_turn <= 1'b0;
               sw_count <= 5'h00;
            end
            else
               master_ord_start <= 1'b1;
         end
         else if (sw_active && !pre_busy && !sw_mode)
            sw_active <= 1'b0;
         else if (sw_active && !pre_busy && converter_clock)
         begin
            if (sw_count == 5'h00)
            begin
               slave_ord_start <= !sw_turn;
               master_ord_start <= sw_turn;
               sw_turn <= !sw_turn;
               sw_count <= gap - 5'h01;
            end
            else
               sw_count <= sw_count - 5'h01;
         end
      end
   end
endmodule

// ---- rtl/conv_backend_defs.vh ----
/*
 converter back end: register offsets, field positions, reset values, mode codes, timing.
 assumes one 40 MHz clock and word-only APB access.
*/
`ifndef CONV_BACKEND_DEFS_VH
`define CONV_BACKEND_DEFS_VH
// ==========================================================
// register byte offsets
`define OFF_STATUS 12'h000
`define OFF_CTRL_ONE 12'h004
`define OFF_CTRL_TWO 12'h008
`define OFF_SPT_ONE 12'h00c
`define OFF_SPT_TWO 12'h010
`define OFF_POFS_ONE 12'h014
`define OFF_POFS_TWO 12'h018
`define OFF_POFS_THREE 12'h01c
`define OFF_POFS_FOUR 12'h020
`define OFF_HIGH 12'h024
`define OFF_LOW 12'h028
`define OFF_OSQ_ONE 12'h02c
`define OFF_OSQ_TWO 12'h030
`define OFF_OSQ_THREE 12'h034
`define OFF_PSQ 12'h038
`define OFF_PRES_ONE 12'h03c
`define OFF_PRES_TWO 12'h040
`define OFF_PRES_THREE 12'h044
`define OFF_PRES_FOUR 12'h048
`define OFF_ORES 12'h04c
`define OFF_IRQ_EN 12'h050
// ==========================================================
// reset values
`define RST_ZERO 32'h0000_0000
`define RST_HIGH 12'hfff
// ==========================================================
// status bits
`define ST_RANGE 0
`define ST_CEND 1
`define ST_PEND 2
`define ST_PSTART 3
`define ST_OSTART 4
// control_one fields
`define C1_CHSEL_LO 0
`define C1_CHSEL_HI 4
`define C1_SINGLE 9
`define C1_MODE_LO 16
`define C1_MODE_HI 19
`define C1_PMON 22
`define C1_OMON 23
// control_two fields
`define C2_DMA 8
`define C2_ALIGN 11
// interrupt enable fields
`define IE_RANGE 0
`define IE_CEND 1
`define IE_PEND 2
// ==========================================================
// pairing mode codes
`define MODE_INDEP 4'h0
`define MODE_REG_PRE_SIM 4'h1
`define MODE_REG_ALT 4'h2
`define MODE_PSIM_FAST 4'h3
`define MODE_PSIM_SLOW 4'h4
`define MODE_PRE_SIM 4'h5
`define MODE_REG_SIM 4'h6
`define MODE_FAST 4'h7
`define MODE_SLOW 4'h8
`define MODE_ALT 4'h9
// ==========================================================
// switch intervals in converter clock cycles
`define FAST_GAP 5'h07
`define SLOW_GAP 5'h0e
`endif

// ---- verification/conv_backend_asserts.sv ----
/*
 checker for conv_backend: start pairing, switch spacing, dma request, apb errors.
 assumes it is bound into conv_backend and the defs header is on the include path.
*/
`include "conv_backend_defs.vh"
module conv_backend_asserts (
   input wire ref_clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pslverr,
   input wire converter_clock,
   input wire pre_trigger,
   input wire ord_done,
   input wire master_ord_start,
   input wire slave_ord_start,
   input wire master_pre_start,
   input wire slave_pre_start,
   input wire dma_request,
   input wire dma_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [3:0] mode;
   reg [4:0] ccnt;
   // ==========================================================
   // pairing mode snoop and converter clock count since last start
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode <= 4'h0;
         ccnt <= 5'h00;
      end
      else
      begin
         if (psel && penable && pwrite && paddr == `OFF_CTRL_ONE)
            mode <= (pwdata[19:16] > 4'h9) ? 4'h0 : pwdata[19:16];
         if (master_ord_start || slave_ord_start)
            ccnt <= {4'h0, converter_clock};
         else
            ccnt <= ccnt + {4'h0, converter_clock};
      end
   end
   // ==========================================================
   // properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence apb_acc;
      psel && penable;
   endsequence
   sequence dma_wait;
      dma_request && !dma_ack;
   endsequence
   bad_addr_a: assert property (apb_acc ##0 (paddr[1:0] != 2'h0 || paddr > 12'h050)
      |-> pslverr) else $error("no slave error on bad address");
   good_addr_a: assert property (apb_acc ##0 (paddr[1:0] == 2'h0 && paddr < 12'h054)
      |-> !pslverr) else $error("slave error on mapped address");
   sim_reg_a: assert property ((mode == `MODE_REG_SIM || mode == `MODE_REG_PRE_SIM)
      && master_ord_start |-> slave_ord_start) else $error("regular start not paired");
   sim_pre_a: assert property ((mode == `MODE_PRE_SIM || mode == `MODE_REG_PRE_SIM)
      && master_pre_start |-> slave_pre_start) else $error("preempted start not paired");
   alt_one_a: assert property (mode == `MODE_ALT |-> !(master_pre_start && slave_pre_start))
      else $error("both converters took one alternate trigger");
   pre_cause_a: assert property (master_pre_start || slave_pre_start |-> $past(pre_trigger))
      else $error("preempted start without trigger");
   fast_gap_a: assert property (mode == `MODE_FAST && master_ord_start
      |-> ccnt == `FAST_GAP) else $error("fast switch spacing wrong");
   slow_gap_a: assert property (mode == `MODE_SLOW && master_ord_start
      |-> ccnt == `SLOW_GAP) else $error("slow switch spacing wrong");
   dma_cause_a: assert property ($rose(dma_request) |-> $past(ord_done))
      else $error("dma request without ordinary result");
   dma_hold_a: assert property (dma_wait |=> dma_request)
      else $error("dma request dropped before acknowledge");
endmodule
bind conv_backend conv_backend_asserts chk (.*);

// ---- verification/conv_backend_tb.sv ----
/*
 self-checking bench for conv_backend: results, offsets, monitor, flags, pairing modes.
 assumes the defs header on the include path and a 40 MHz reference clock.
*/
`include "conv_backend_defs.vh"
module conv_backend_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic converter_clock = 1'h0, ord_trigger = 1'h0, pre_trigger = 1'h0, ord_done = 1'h0;
   logic ord_from_slave = 1'h0, pre_done = 1'h0, pre_group_end = 1'h0, perr;
   logic pready, pslverr, master_ord_start, slave_ord_start, master_pre_start, slave_pre_start;
   logic ord_halt, dma_request, dma_ack, irq_shared;
   logic [11:0] paddr = '0, ord_value = '0, pre_value = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [4:0] ord_channel = '0, pre_channel = '0;
   logic [1:0] pre_position = '0;
   logic [3:0] seen, delay = 4'h6;
   int err_count = 0, checks = 0, served, n;
   typedef struct {logic pre; logic [1:0] pos; logic left;
      logic [11:0] ofs, v; logic [31:0] exp;} row_t;
   row_t rows [6] = '{'{1'h0, 2'h0, 1'h0, 12'h000, 12'habc, 32'h00000abc},
      '{1'h0, 2'h1, 1'h1, 12'h000, 12'habc, 32'h0000abc0},
      '{1'h1, 2'h0, 1'h0, 12'h100, 12'h0ff, 32'h0000ffff},
      '{1'h1, 2'h1, 1'h1, 12'h010, 12'h00f, 32'h0000fff0},
      '{1'h1, 2'h2, 1'h0, 12'h000, 12'hfff, 32'h00000fff},
      '{1'h1, 2'h3, 1'h0, 12'h005, 12'h800, 32'h000007fb}};
   conv_backend DUT (.*);
   dma_responder dma (.*);
   // reference clock and converter clock enable
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) converter_clock <= ~converter_clock;
   // ==========================================================
   // tasks
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
         @(posedge ref_clk);
      while (pready !== 1'h1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic ord_conv(input logic [11:0] v, input logic [4:0] ch, input logic fs);
      ord_value <= v;
      ord_channel <= ch;
      ord_from_slave <= fs;
      ord_done <= 1'h1;
      @(posedge ref_clk);
      ord_done <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic pre_conv(input logic [1:0] p, input logic [11:0] v, input logic [4:0] ch);
      pre_position <= p;
      pre_value <= v;
      pre_channel <= ch;
      pre_done <= 1'h1;
      @(posedge ref_clk);
      pre_done <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic mode(input logic [3:0] m);
      pre_group_end <= 1'h1;
      @(posedge ref_clk);
      pre_group_end <= 1'h0;
      apb(1'h1, `OFF_CTRL_ONE, {12'h0, m, 16'h0});
   endtask
   task automatic trig(input logic pre, input logic [3:0] exp);
      ord_trigger <= !pre;
      pre_trigger <= pre;
      @(posedge ref_clk);
      ord_trigger <= 1'h0;
      pre_trigger <= 1'h0;
      seen = '0;
      repeat (2)
      begin
         #1;
         seen |= {master_ord_start, slave_ord_start, master_pre_start, slave_pre_start};
         @(posedge ref_clk);
      end
      cmp("starts", {28'h0, exp}, {28'h0, seen});
   endtask
   task automatic sw(input logic [3:0] m, input int gap);
      mode(m);
      ord_trigger <= 1'h1;
      @(posedge ref_clk);
      ord_trigger <= 1'h0;
      do
      begin
         @(posedge ref_clk);
         #1;
      end
      while (slave_ord_start !== 1'h1 && master_ord_start !== 1'h1);
      cmp("slave first", 32'h1, {31'h0, slave_ord_start});
      n = 0;
      while (master_ord_start !== 1'h1)
      begin
         n += converter_clock;
         @(posedge ref_clk);
         #1;
      end
      cmp("switch gap", gap, n);
      @(posedge ref_clk);
      mode(`MODE_INDEP);
   endtask
   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      summarize();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      foreach (rows[i])
      begin
         apb(1'h1, `OFF_CTRL_TWO, {20'h0, rows[i].left, 3'h1, 8'h00});
         if (rows[i].pre)
         begin
            apb(1'h1, `OFF_POFS_ONE + {8'h0, rows[i].pos, 2'h0}, {20'h0, rows[i].ofs});
            pre_conv(rows[i].pos, rows[i].v, 5'h01);
            apb(1'h0, `OFF_PRES_ONE + {8'h0, rows[i].pos, 2'h0}, '0);
         end
         else
         begin
            ord_conv(rows[i].v, 5'h01, rows[i].pos[0]);
            apb(1'h0, `OFF_ORES, '0);
         end
         cmp("result", rows[i].exp, rd);
         delay <= 4'h0;
      end
      cmp("dma served", 32'h2, served);
      apb(1'h0, `OFF_ORES, '0);
      cmp("ordinary held", 32'h0000abc0, rd);
      // monitor: bounds 0x100..0x800, single channel 3, left aligned
      apb(1'h1, `OFF_HIGH, 32'h00000800);
      apb(1'h1, `OFF_LOW, 32'h00000100);
      apb(1'h1, `OFF_CTRL_ONE, 32'h00c00203);
      apb(1'h1, `OFF_CTRL_TWO, 32'h00000800);
      apb(1'h1, `OFF_STATUS, '0);
      ord_conv(12'hf00, 5'h05, 1'h0);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("range other channel", 32'h0, rd & 32'h1);
      pre_conv(2'h0, 12'h150, 5'h03);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("range raw value", 32'h0, rd & 32'h1);
      ord_conv(12'hf00, 5'h03, 1'h0);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("range high", 32'h1, rd & 32'h1);
      apb(1'h1, `OFF_STATUS, '0);
      pre_conv(2'h0, 12'h0f0, 5'h03);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("range low", 32'h1, rd & 32'h1);
      // flags and interrupt
      apb(1'h1, `OFF_STATUS, '0);
      apb(1'h1, `OFF_IRQ_EN, 32'h00000002);
      ord_conv(12'h123, 5'h03, 1'h0);
      cmp("irq on", 32'h1, {31'h0, irq_shared});
      apb(1'h0, `OFF_ORES, '0);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("end cleared by read", 32'h0, rd & 32'h2);
      cmp("irq off", 32'h0, {31'h0, irq_shared});
      ord_conv(12'h123, 5'h03, 1'h0);
      apb(1'h1, `OFF_STATUS, '0);
      apb(1'h0, `OFF_STATUS, '0);
      cmp("end cleared by write", 32'h0, rd & 32'h2);
      // pairing modes
      mode(`MODE_INDEP);
      trig(1'h0, 4'h8);
      mode(`MODE_REG_SIM);
      trig(1'h0, 4'hc);
      mode(`MODE_PRE_SIM);
      trig(1'h1, 4'h3);
      mode(`MODE_REG_PRE_SIM);
      trig(1'h0, 4'hc);
      trig(1'h1, 4'h3);
      mode(`MODE_ALT);
      trig(1'h1, 4'h2);
      trig(1'h1, 4'h1);
      mode(`MODE_REG_ALT);
      trig(1'h1, 4'h2);
      trig(1'h1, 4'h0);
      cmp("halt", 32'h1, {31'h0, ord_halt});
      mode(`MODE_REG_ALT);
      trig(1'h1, 4'h1);
      sw(`MODE_FAST, 7);
      sw(`MODE_PSIM_FAST, 7);
      sw(`MODE_SLOW, 14);
      sw(`MODE_PSIM_SLOW, 14);
      mode(4'ha);
      apb(1'h0, `OFF_CTRL_ONE, '0);
      cmp("mode not allowed", 32'h0, rd & 32'h000f0000);
      // bad addresses, then a second reset and the reset values
      apb(1'h0, 12'h054, '0);
      cmp("unmapped error", 32'h1, {31'h0, perr});
      cmp("unmapped data", 32'h0, rd);
      apb(1'h1, 12'h006, 32'hffffffff);
      cmp("unaligned error", 32'h1, {31'h0, perr});
      reset_n <= 1'h0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      for (int a = 0; a < 'h54; a += 4)
      begin
         apb(1'h0, a[11:0], '0);
         cmp("reset value", (a == 'h24) ? 32'h00000fff : 32'h0, rd);
         cmp("mapped error", 32'h0, {31'h0, perr});
      end
      summarize();
   end
endmodule

// ---- verification/dma_responder.sv ----
/*
 dma side model: answers each dma request with a one-cycle acknowledge after a wait.
 assumes the request stays high until acknowledged.
*/
module dma_responder (
   input wire ref_clk,
   input wire reset_n,
   input wire dma_request,
   input wire [3:0] delay,
   output logic dma_ack,
   output int served
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wt;
   // wait delay cycles, then take the ordinary result once
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dma_ack <= 1'h0;
         wt <= 4'h0;
         served <= 0;
      end
      else if (dma_ack)
      begin
         dma_ack <= 1'h0;
         wt <= 4'h0;
      end
      else if (dma_request && wt >= delay)
      begin
         dma_ack <= 1'h1;
         served <= served + 1;
      end
      else if (dma_request)
         wt <= wt + 4'h1;
   end
endmodule
